// ===== bench/kcm_menu_tb.sv
// Self-checking bench for the keypad menu against a behavioural model
`timescale 1ns/10ps
module kcm_menu_tb;
  localparam int K_MODE = 6, K_VIEW = 5, K_INC = 4, K_DEC = 3, K_LOAD = 2, K_CLR = 1, K_FUNC = 0;
  logic clk_sys, rst, panel_present, sup_pending, sup_z2, cipher_ok, init_done;
  kcm_pkg::kcm_key_t keys_raw;
  kcm_pkg::kcm_stat_t status;
  logic [6:0] peak_level, disp_val;
  logic cfg_active, level_active, alarm_suppress, level_zone, level_manual, disp_dp;
  logic zone_two_supervision_code, sup_ack, commit, init_req;
  logic [1:0] view_sel;
  logic [3:0] level_idx;
  logic [4:0] param_sel;
  kcm_pkg::kcm_store_t param_store;
  int n_fail = 0, n_compared = 0, cycles = 0, n_ack = 0, n_commit = 0, n_init = 0, w;
  int seed = 32'h61801f5e;
  // Reference model state and pulse expectations
  int m_cfg = 0, m_lvl = 0, m_view = 0, m_idx = 5, m_man = 0, m_item = 0, m_val = 0;
  int m_prev = 0, m_arm = 0, m_na = 0, m_nc = 0, m_ni = 0;
  int st[22];
  int dflt[22] = '{30, 10, 4, 20, 10, 2, 30, 10, 4, 20, 10, 2, 2, 2, 3, 10, 0, 2, 2, 3, 10, 0};

  kcm_menu #(.DEB_CYC(4), .HOLD_CYC(20), .SUP2_CYC(10)) kcm_menu_i (
    .clk_sys(clk_sys), .rst(rst), .panel_present(panel_present), .keys_raw(keys_raw),
    .sup_pending(sup_pending), .sup_z2(sup_z2), .cipher_ok(cipher_ok),
    .init_done(init_done), .status(status), .peak_level(peak_level),
    .cfg_active(cfg_active), .level_active(level_active), .alarm_suppress(alarm_suppress),
    .view_sel(view_sel), .level_zone(level_zone), .level_idx(level_idx),
    .level_manual(level_manual), .param_sel(param_sel), .disp_val(disp_val),
    .disp_dp(disp_dp), .zone_two_supervision_code(zone_two_supervision_code),
    .sup_ack(sup_ack), .commit(commit), .init_req(init_req), .param_store(param_store)
  );
  kcm_panel_model kcm_panel_model_i (
    .clk_sys(clk_sys),
    .keys_raw(keys_raw)
  );

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Pulse counters and hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (sup_ack === 1'b1) n_ack++;
    if (commit === 1'b1) n_commit++;
    if (init_req === 1'b1) n_init++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic cmp_val(input string nm, input logic [6:0] e, input logic [6:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : cmp_val

  task automatic cmp_flag(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_flag

  // Edit limits of the threat items, per zone
  function automatic int lim(input int i, input int hi);
    int z;
    z = (i / 6) * 6;
    case (i % 6)
      0: return hi ? 99 : 1;
      1, 4: return hi ? 20 : 1;
      2: return hi ? 10 : 1;
      3: return hi ? 99 : st[z + 5];
      default: return hi ? st[z + 3] : 1;
    endcase
  endfunction : lim

  // Reference reaction to one press
  task automatic model(input int k);
    // Pending supervision message: only Clear acts
    if (!m_cfg && !m_lvl && sup_pending === 1'b1) begin
      if (k == K_CLR) m_na++;
      return;
    end
    if (m_cfg) begin
      case (k)
        K_MODE: begin
          m_cfg = 0;
          m_view = 0;
          m_ni++;
        end
        K_VIEW: begin
          m_item = (m_item + 1) % 12;
          m_val = st[m_item];
        end
        K_INC: m_val = (m_val < lim(m_item, 1)) ? m_val + 1 : lim(m_item, 1);
        K_DEC: m_val = (m_val > lim(m_item, 0)) ? m_val - 1 : lim(m_item, 0);
        K_LOAD: begin
          if (m_prev == K_INC || m_prev == K_DEC) begin
            st[m_item] = m_val;
            m_nc++;
          end
        end
        K_CLR: begin
          if (m_arm) begin
            st = dflt;
            m_val = st[m_item];
            m_nc++;
          end
        end
        K_FUNC: begin
          // Arming looks at the item selected before any paging
          m_arm = (m_item == 0);
          if (cipher_ok === 1'b1) begin
            m_item = (m_item < 12) ? 12 : 0;
            m_val = st[m_item];
          end
        end
        default: ;
      endcase
      if (k != K_FUNC) m_arm = 0;
      m_prev = k;
    end else if (m_lvl) begin
      case (k)
        K_INC: m_idx = (m_idx < 12) ? m_idx + 1 : 12;
        K_DEC: m_idx = (m_idx > 0) ? m_idx - 1 : 0;
        K_CLR: m_man = 1;
        K_FUNC: begin
          m_lvl = 0;
          m_view = 0;
        end
        default: ;
      endcase
    end else begin
      case (k)
        K_MODE: begin
          m_cfg = 1;
          m_item = 0;
          m_val = st[0];
          m_prev = K_MODE;
        end
        K_VIEW: m_view = (m_view + 1) % 4;
        K_FUNC: begin
          m_lvl = 1;
          m_idx = 5;
          m_man = 0;
        end
        default: ;
      endcase
    end
  endtask : model

  // Compare the mode flags, pulse counts, current-mode outputs and store with the model
  task automatic check();
    logic [27:0] sv;
    int d;
    sv = status;
    d = 0;
    foreach (st[i]) if (st[i] != dflt[i]) d = 1;
    cmp_flag("cfg_active", m_cfg[0], cfg_active);
    cmp_flag("level_active", m_lvl[0], level_active);
    cmp_val("sup_ack count", 7'(m_na), 7'(n_ack));
    cmp_val("commit count", 7'(m_nc), 7'(n_commit));
    if (m_cfg) begin
      cmp_val("param_sel", 7'(m_item), {2'b0, param_sel});
      cmp_val("disp_val", 7'(m_val), disp_val);
      cmp_flag("disp_dp", d[0], disp_dp);
    end else if (m_lvl) begin
      cmp_val("level_idx", 7'(m_idx), {3'b0, level_idx});
      cmp_flag("level_manual", m_man[0], level_manual);
      cmp_flag("level_zone", 1'b0, level_zone);
      cmp_flag("alarm_suppress", 1'b1, alarm_suppress);
      if (m_man) cmp_val("disp_val", 7'h00, disp_val);
    end else begin
      cmp_val("view_sel", 7'(m_view), {5'b0, view_sel});
      cmp_flag("alarm_suppress", 1'b0, alarm_suppress);
      if (sup_pending !== 1'b1) begin
        cmp_val("disp_val", 7'(sv >> (7 * (3 - m_view))), disp_val);
      end
    end
    foreach (st[i]) cmp_val("param_store", 7'(st[i]), param_store[i]);
  endtask : check

  task automatic do_key(input int k);
    model(k);
    kcm_panel_model_i.press(k);
    #1 check();
  endtask : do_key

  // Main sequence
  initial begin
    rst = 1'b1;
    panel_present = 1'b1;
    sup_pending = 1'b0;
    sup_z2 = 1'b1;
    cipher_ok = 1'b0;
    init_done = 1'b0;
    peak_level = 7'h00;
    status = 28'($random(seed));
    st = dflt;
    repeat (8) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 check();
    repeat (5) do_key(K_VIEW);
    do_key(K_INC);
    do_key(K_DEC);
    do_key(K_FUNC);
    // Auto readout: a captured peak stands, then clears after the hold time
    peak_level = 7'($random(seed)) | 7'h01;
    repeat (3) @(posedge clk_sys);
    #1 cmp_val("disp_val", peak_level, disp_val);
    peak_level = 7'h00;
    repeat (24) @(posedge clk_sys);
    #1 cmp_val("disp_val", 7'h00, disp_val);
    peak_level = 7'($random(seed));
    repeat (9) do_key(K_INC);
    do_key(K_DEC);
    peak_level = 7'h00;
    do_key(K_CLR);
    do_key(K_FUNC);
    sup_pending = 1'b1;
    do_key(K_VIEW);
    do_key(K_MODE);
    do_key(K_CLR);
    sup_pending = 1'b0;
    do_key(K_MODE);
    do_key(K_INC);
    do_key(K_LOAD);
    do_key(K_VIEW);
    do_key(K_DEC);
    do_key(K_VIEW);
    do_key(K_LOAD);
    repeat (11) do_key(K_VIEW);
    repeat (11) do_key(K_INC);
    do_key(K_LOAD);
    do_key(K_CLR);
    do_key(K_FUNC);
    repeat (11) do_key(K_VIEW);
    do_key(K_FUNC);
    do_key(K_CLR);
    // Access code accepted: page to functional items and back
    cipher_ok = 1'b1;
    repeat (2) do_key(K_FUNC);
    cipher_ok = 1'b0;
    model(K_MODE);
    kcm_panel_model_i.press(K_MODE);
    #1 cmp_val("init_req count", 7'(m_ni), 7'(n_init));
    @(posedge clk_sys);
    #1 init_done = 1'b1;
    @(posedge clk_sys);
    #1 init_done = 1'b0;
    w = 0;
    while (zone_two_supervision_code !== 1'b1 && w < 8) begin
      @(posedge clk_sys);
      w++;
    end
    #1 cmp_flag("zone_two_supervision_code", 1'b1, zone_two_supervision_code);
    cmp_val("disp_val", 7'h01, disp_val);
    repeat (20) @(posedge clk_sys);
    #1 check();
    do_key(K_MODE);
    panel_present = 1'b0;
    m_cfg = 0;
    m_view = 0;
    repeat (4) @(posedge clk_sys);
    #1 check();
    conclude();
  end
endmodule : kcm_menu_tb

// ===== bench/kcm_panel_model.sv
// Operator keypad model: raw key levels with contact bounce
`timescale 1ns/10ps
module kcm_panel_model (
  input wire logic clk_sys,
  output kcm_pkg::kcm_key_t keys_raw
);
  // Random hold lengths, fixed seed
  int seed = 32'h61801f5e;
  initial keys_raw = '0;
  // One press: short bounce, steady hold, then release with idle gap
  task automatic press(input int k);
    int hold;
    hold = 20 + ($unsigned($random(seed)) % 16);
    @(posedge clk_sys);
    #1 keys_raw[k] = 1'b1;
    @(posedge clk_sys);
    #1 keys_raw[k] = 1'b0;
    // Glitch above is too short to survive three samples
    repeat (2) @(posedge clk_sys);
    #1 keys_raw[k] = 1'b1;
    // Long holds must still give a single action
    repeat (hold) @(posedge clk_sys);
    #1 keys_raw[k] = 1'b0;
    repeat (16) @(posedge clk_sys);
  endtask : press
endmodule : kcm_panel_model

// ===== rtl/kcm_debounce.sv
// Key debouncer: three stable samples on a slow tick, one pulse per press
`timescale 1ns/10ps
`include "kcm_defs.svh"
module kcm_debounce #(
  parameter int DEB_CYC = `KCM_DEB_MS * `KCM_CLK_MHZ * 1000
) (
  input wire logic clk_sys,
  input wire logic rst,
  input kcm_pkg::kcm_key_t keys_raw,
  output kcm_pkg::kcm_key_t keys_press
);
  kcm_pkg::kcm_deb_t s_r; // All state
  kcm_pkg::kcm_deb_t s_nxt; // Next state
  logic tick; // Sample enable

  // Divider and sampling; a held key never repeats
  always_comb begin
    s_nxt = s_r;
    s_nxt.press = '0;
    tick = (s_r.cnt == 20'(DEB_CYC - 1));
    s_nxt.cnt = tick ? 20'h00000 : s_r.cnt + 20'h00001;
    if (tick) begin
      s_nxt.s0 = keys_raw;
      s_nxt.s1 = s_r.s0;
      s_nxt.s2 = s_r.s1;
      // Only all-agreeing samples move the stable value
      s_nxt.stable = (s_r.stable & (s_r.s0 | s_r.s1 | s_r.s2)) |
        (s_r.s0 & s_r.s1 & s_r.s2);
      s_nxt.press = s_nxt.stable & ~s_r.stable;
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign keys_press = s_r.press;
endmodule : kcm_debounce

// ===== rtl/kcm_defs.svh
// Constants for the keypad configuration menu: limits, defaults, timing
`ifndef KCM_DEFS_SVH
`define KCM_DEFS_SVH
`define KCM_CLK_MHZ 100
`define KCM_DEB_MS 5
`define KCM_HOLD_MS 2000
`define KCM_SUP2_MS 1000
`define KCM_NPARAM 22
`define KCM_NTHREAT 12
`define KCM_LVL_RST 4'h5
`define KCM_LVL_MAX 4'hc
`define KCM_MAX_SEC 7'h63
`define KCM_THR_MAX 7'h14
`define KCM_CNT_MAX 7'h0a
`define KCM_AMB_MAX 7'h0a
`define KCM_CMN_MAX 7'h01
`define KCM_DEF_CUT_TW 7'h1e
`define KCM_DEF_THR 7'h0a
`define KCM_DEF_CUT_CNT 7'h04
`define KCM_DEF_CLB_TW 7'h14
`define KCM_DEF_CLB_TIME 7'h02
`define KCM_DEF_RELAY 7'h02
`define KCM_DEF_PROFILE 7'h02
`define KCM_DEF_PEAK 7'h03
`define KCM_DEF_AMB 7'h0a
`define KCM_DEF_CMN 7'h00
`endif

// ===== rtl/kcm_menu.sv
// Keypad menu state machine of the two-zone configuration panel
// How it works
// - Mode key toggles monitor and configure
// - Entering configure selects zone 1 cut window
// - Leaving configure runs init, no reset
// - Absent panel forces monitor state
// - View key cycles four monitor status views
// - Function key enters level view, register 5
// - Level view suppresses alarm reporting
// - Increase raises level index up to 12
// - Decrease lowers level index by one
// - Pending supervision alarm in monitor display: only Clear acts
// - Level Clear zeroes display, selects held
// - Function key leaves level view
// - View key cycles threat parameters in order
// - Increase/Decrease change parameter by one
// - Load commits only right after edit
// - Clear acts in configure only right after Function
// - Function key pages only with access code
// - Decimal point marks non-default parameters
// - Function on zone 1 cut window then Clear restores defaults
// - Threat defaults 30,10,4,20,10,2 per zone
// - Functional defaults 2,02,03,10,00
// - Return shows zone 2 supervision briefly
// - Window limits 1..99, climb from climb time
// - Thresholds limited 1..20
// - Auto readout holds peak two seconds
`timescale 1ns/10ps
`include "kcm_defs.svh"
module kcm_menu #(
  parameter int DEB_CYC = `KCM_DEB_MS * `KCM_CLK_MHZ * 1000,
  parameter int HOLD_CYC = `KCM_HOLD_MS * `KCM_CLK_MHZ * 1000,
  parameter int SUP2_CYC = `KCM_SUP2_MS * `KCM_CLK_MHZ * 1000
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic panel_present,
  input kcm_pkg::kcm_key_t keys_raw,
  input wire logic sup_pending,
  input wire logic sup_z2,
  input wire logic cipher_ok,
  input wire logic init_done,
  input kcm_pkg::kcm_stat_t status,
  input wire logic [6:0] peak_level,
  output logic cfg_active,
  output logic level_active,
  output logic alarm_suppress,
  output logic [1:0] view_sel,
  output logic level_zone,
  output logic [3:0] level_idx,
  output logic level_manual,
  output logic [4:0] param_sel,
  output logic [6:0] disp_val,
  output logic disp_dp,
  output logic zone_two_supervision_code,
  output logic sup_ack,
  output logic commit,
  output logic init_req,
  output kcm_pkg::kcm_store_t param_store
);
  // Local names for the menu states; the package is never imported
  localparam kcm_pkg::kcm_mode_t MON_DISP = kcm_pkg::MON_DISP, MON_LEVEL = kcm_pkg::MON_LEVEL;
  localparam kcm_pkg::kcm_mode_t CFG = kcm_pkg::CFG, INIT = kcm_pkg::INIT, SUP2 = kcm_pkg::SUP2;
  kcm_pkg::kcm_state_t s_r; // All state
  kcm_pkg::kcm_state_t s_nxt; // Next state
  kcm_pkg::kcm_key_t press; // Debounced press pulses
  kcm_pkg::kcm_key_t k; // Presses gated by panel presence

  // Factory value of a parameter index
  function automatic logic [6:0] dflt(input logic [4:0] i);
    logic [4:0] j;
    j = (i < 5'd12) ? ((i < 5'd6) ? i : i - 5'd6) : 5'd6 + ((i - 5'd12) % 5'd5);
    case (j)
      5'd0: dflt = `KCM_DEF_CUT_TW;
      5'd1: dflt = `KCM_DEF_THR;
      5'd2: dflt = `KCM_DEF_CUT_CNT;
      5'd3: dflt = `KCM_DEF_CLB_TW;
      5'd4: dflt = `KCM_DEF_THR;
      5'd5: dflt = `KCM_DEF_CLB_TIME;
      5'd6: dflt = `KCM_DEF_RELAY;
      5'd7: dflt = `KCM_DEF_PROFILE;
      5'd8: dflt = `KCM_DEF_PEAK;
      5'd9: dflt = `KCM_DEF_AMB;
      default: dflt = `KCM_DEF_CMN;
    endcase
  endfunction : dflt

  // Upper limit; climb time is capped by its own zone's window
  function automatic logic [6:0] lim_hi(input logic [4:0] i, input kcm_pkg::kcm_store_t st);
    logic [4:0] b;
    b = (i < 5'd6) ? 5'd0 : 5'd6;
    if (i >= 5'd12) begin
      case ((i - 5'd12) % 5'd5)
        5'd3: lim_hi = `KCM_AMB_MAX;
        5'd4: lim_hi = `KCM_CMN_MAX;
        default: lim_hi = `KCM_MAX_SEC;
      endcase
    end else begin
      case (i - b)
        5'd1, 5'd4: lim_hi = `KCM_THR_MAX;
        5'd2: lim_hi = `KCM_CNT_MAX;
        5'd5: lim_hi = st[b + 5'd3];
        default: lim_hi = `KCM_MAX_SEC;
      endcase
    end
  endfunction : lim_hi

  // Lower limit; climb window may not fall under climb time
  function automatic logic [6:0] lim_lo(input logic [4:0] i, input kcm_pkg::kcm_store_t st);
    logic [4:0] b;
    b = (i < 5'd6) ? 5'd0 : 5'd6;
    if (i >= 5'd12) begin
      lim_lo = (((i - 5'd12) % 5'd5) == 5'd0) ? 7'h01 : 7'h00;
    end else if ((i - b) == 5'd3) begin
      lim_lo = st[b + 5'd5];
    end else begin
      lim_lo = 7'h01;
    end
  endfunction : lim_lo

  kcm_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
    .clk_sys(clk_sys),
    .rst(rst),
    .keys_raw(keys_raw),
    .keys_press(press)
  );

  assign k = panel_present ? press : '0;

  // Menu decoding; at most one key acts, priority in branch order
  always_comb begin
    s_nxt = s_r;
    s_nxt.sup_ack = 1'b0;
    s_nxt.commit = 1'b0;
    s_nxt.init_req = 1'b0;
    if (s_r.timer != 28'h0000000) begin
      s_nxt.timer = s_r.timer - 28'h0000001;
    end
    case (s_r.st)
      MON_DISP: begin
        if (sup_pending) begin
          // Other keys are dropped while sup_pending is high
          s_nxt.sup_ack = k.clr;
        end else if (k.mode) begin
          s_nxt.st = CFG;
          s_nxt.item = 5'd0;
          s_nxt.edit_val = s_r.store[0];
          s_nxt.edit_live = 1'b0;
          s_nxt.restore_arm = 1'b0;
        end else if (k.view) begin
          s_nxt.view = s_r.view + 2'd1;
        end else if (k.func) begin
          s_nxt.st = MON_LEVEL;
          s_nxt.lvl_zone = 1'b0;
          s_nxt.lvl_idx = `KCM_LVL_RST;
          s_nxt.lvl_manual = 1'b0;
          s_nxt.lvl_val = 7'h00;
        end
      end
      MON_LEVEL: begin
        // Peak capture; auto readout clears after the hold time
        if (peak_level > s_r.lvl_val) begin
          s_nxt.lvl_val = peak_level;
          s_nxt.timer = 28'(HOLD_CYC);
        end else if (!s_r.lvl_manual && s_r.timer == 28'h0000001) begin
          s_nxt.lvl_val = 7'h00;
        end
        if (k.mode) begin
          s_nxt.st = CFG;
          s_nxt.item = 5'd0;
          s_nxt.edit_val = s_r.store[0];
          s_nxt.edit_live = 1'b0;
          s_nxt.restore_arm = 1'b0;
        end else if (k.func) begin
          s_nxt.st = MON_DISP;
          s_nxt.view = 2'd0;
        end else if (k.view) begin
          s_nxt.lvl_zone = ~s_r.lvl_zone;
        end else if (k.inc && s_r.lvl_idx != `KCM_LVL_MAX) begin
          s_nxt.lvl_idx = s_r.lvl_idx + 4'h1;
        end else if (k.dec && s_r.lvl_idx != 4'h0) begin
          s_nxt.lvl_idx = s_r.lvl_idx - 4'h1;
        end else if (k.clr) begin
          s_nxt.lvl_val = 7'h00;
          s_nxt.lvl_manual = 1'b1;
          s_nxt.timer = 28'h0000000;
        end
      end
      CFG: begin
        // Any key but Increase/Decrease ends an edit; the stored value returns
        if (k != '0) begin
          s_nxt.edit_live = 1'b0;
          s_nxt.edit_val = s_r.store[s_r.item];
          s_nxt.restore_arm = 1'b0;
        end
        if (k.mode) begin
          s_nxt.st = INIT;
          s_nxt.init_req = 1'b1;
        end else if (k.view) begin
          if (s_r.item == 5'd11 || s_r.item == 5'd21) begin
            s_nxt.item = (s_r.item == 5'd11) ? 5'd0 : 5'd12;
          end else begin
            s_nxt.item = s_r.item + 5'd1;
          end
          s_nxt.edit_val = s_r.store[s_nxt.item];
        end else if (k.inc || k.dec) begin
          s_nxt.edit_live = 1'b1;
          s_nxt.edit_val = s_r.edit_val;
          if (k.inc && s_r.edit_val < lim_hi(s_r.item, s_r.store)) begin
            s_nxt.edit_val = s_r.edit_val + 7'h01;
          end else if (k.dec && s_r.edit_val > lim_lo(s_r.item, s_r.store)) begin
            s_nxt.edit_val = s_r.edit_val - 7'h01;
          end
        end else if (k.load && s_r.edit_live) begin
          s_nxt.store[s_r.item] = s_r.edit_val;
          s_nxt.edit_val = s_r.edit_val;
          s_nxt.commit = 1'b1;
        end else if (k.func) begin
          s_nxt.restore_arm = (s_r.item == 5'd0);
          if (cipher_ok) begin
            s_nxt.item = (s_r.item < 5'd12) ? 5'd12 : 5'd0;
            s_nxt.edit_val = s_r.store[s_nxt.item];
          end
        end else if (k.clr && s_r.restore_arm) begin
          // Clear alone is inert here
          for (int i = 0; i < `KCM_NPARAM; i++) begin
            s_nxt.store[i] = dflt(5'(i));
          end
          s_nxt.edit_val = dflt(s_r.item);
          s_nxt.commit = 1'b1;
        end
      end
      INIT: begin
        // Startup routine runs outside; only its completion is awaited
        if (init_done) begin
          s_nxt.st = SUP2;
          s_nxt.timer = 28'(SUP2_CYC);
        end
      end
      SUP2: begin
        if (s_r.timer == 28'h0000001) begin
          s_nxt.st = MON_DISP;
          s_nxt.view = 2'd0;
        end
      end
      default: s_nxt.st = MON_DISP;
    endcase
    if (!panel_present) begin
      s_nxt.st = MON_DISP;
      s_nxt.view = 2'd0;
    end
    // Registered display content
    s_nxt.dp = 1'b0;
    for (int i = 0; i < `KCM_NPARAM; i++) begin
      if (s_nxt.store[i] != dflt(5'(i))) begin
        s_nxt.dp = (s_nxt.st == CFG);
      end
    end
    case (s_nxt.st)
      MON_DISP: begin
        case (s_nxt.view)
          2'd0: s_nxt.disp = status.cut_z1;
          2'd1: s_nxt.disp = status.climb_z1;
          2'd2: s_nxt.disp = status.cut_z2;
          default: s_nxt.disp = status.climb_z2;
        endcase
      end
      MON_LEVEL: s_nxt.disp = s_nxt.lvl_val;
      CFG: s_nxt.disp = s_nxt.edit_val;
      SUP2: s_nxt.disp = {6'h00, sup_z2};
      default: s_nxt.disp = 7'h00;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      for (int i = 0; i < `KCM_NPARAM; i++) begin
        s_r.store[i] <= dflt(5'(i));
      end
      s_r.lvl_idx <= `KCM_LVL_RST;
      s_r.st <= MON_DISP;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cfg_active = (s_r.st == CFG);
  assign level_active = (s_r.st == MON_LEVEL);
  assign alarm_suppress = (s_r.st != MON_DISP);
  assign view_sel = s_r.view;
  assign level_zone = s_r.lvl_zone;
  assign level_idx = s_r.lvl_idx;
  assign level_manual = s_r.lvl_manual;
  assign param_sel = s_r.item;
  assign disp_val = s_r.disp;
  assign disp_dp = s_r.dp;
  assign zone_two_supervision_code = (s_r.st == SUP2);
  assign sup_ack = s_r.sup_ack;
  assign commit = s_r.commit;
  assign init_req = s_r.init_req;
  assign param_store = s_r.store;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_mode_to_cfg;
    s_r.st == MON_DISP && !sup_pending && k.mode && panel_present |=> s_r.st == CFG;
  endproperty
  a_mode_to_cfg: assert property (p_mode_to_cfg) else $error("mode key missed");
  property p_first_item;
    $rose(s_r.st == CFG) |-> s_r.item == 5'd0;
  endproperty
  a_first_item: assert property (p_first_item) else $error("wrong first item");
  property p_leave_cfg;
    s_r.st == CFG && k.mode && panel_present |=> s_r.st == INIT && init_req;
  endproperty
  a_leave_cfg: assert property (p_leave_cfg) else $error("init not run");
  property p_absent;
    !panel_present |=> s_r.st == MON_DISP;
  endproperty
  a_absent: assert property (p_absent) else $error("absent not monitor");
  property p_level_entry;
    s_r.st == MON_DISP && !sup_pending && k.func && !k.mode && !k.view && panel_present
      |=> level_active && level_idx == 4'h5 && !level_manual;
  endproperty
  a_level_entry: assert property (p_level_entry) else $error("bad level entry");
  property p_suppress;
    level_active |-> alarm_suppress;
  endproperty
  a_suppress: assert property (p_suppress) else $error("alarm not suppressed");
  property p_idx_range;
    level_idx <= 4'hc;
  endproperty
  a_idx_range: assert property (p_idx_range) else $error("level index range");
  property p_sup_lock;
    s_r.st == MON_DISP && sup_pending && panel_present |=> $stable(s_r.st) && $stable(s_r.view);
  endproperty
  a_sup_lock: assert property (p_sup_lock) else $error("key acted under alarm");
  property p_no_load;
    s_r.st == CFG && !s_r.edit_live && k.load && !k.clr |=> $stable(s_r.store);
  endproperty
  a_no_load: assert property (p_no_load) else $error("stale edit committed");
  property p_restore;
    s_r.st == CFG && s_r.restore_arm && k == 7'h02 && panel_present
      |=> s_r.store[0] == 7'h1e && s_r.store[5] == 7'h02 ##1 !disp_dp;
  endproperty
  a_restore: assert property (p_restore) else $error("restore failed");
  property p_cut_tw;
    s_r.store[0] >= 7'h01 && s_r.store[0] <= 7'h63;
  endproperty
  a_cut_tw: assert property (p_cut_tw) else $error("cut window range");
  c_cfg: cover property (s_r.st == CFG ##[1:1000] commit);
  c_level: cover property (level_active && level_manual);
  c_sup2: cover property (zone_two_supervision_code ##1 s_r.st == MON_DISP);
endmodule : kcm_menu

// ===== rtl/kcm_pkg.sv
// Types shared by the keypad configuration menu modules
package kcm_pkg;
  typedef struct packed {
    logic mode;
    logic view;
    logic inc;
    logic dec;
    logic load;
    logic clr;
    logic func;
  } kcm_key_t;
  typedef struct packed {
    logic [6:0] cut_z1;
    logic [6:0] climb_z1;
    logic [6:0] cut_z2;
    logic [6:0] climb_z2;
  } kcm_stat_t;
  typedef enum logic [2:0] {MON_DISP, MON_LEVEL, CFG, INIT, SUP2} kcm_mode_t;
  typedef logic [21:0][6:0] kcm_store_t;
  typedef struct packed {
    logic [19:0] cnt;
    kcm_key_t s0;
    kcm_key_t s1;
    kcm_key_t s2;
    kcm_key_t stable;
    kcm_key_t press;
  } kcm_deb_t;
  typedef struct packed {
    kcm_mode_t st;
    logic [1:0] view;
    logic lvl_zone;
    logic [3:0] lvl_idx;
    logic lvl_manual;
    logic [6:0] lvl_val;
    logic [27:0] timer;
    logic [4:0] item;
    logic [6:0] edit_val;
    logic edit_live;
    logic restore_arm;
    kcm_store_t store;
    logic [6:0] disp;
    logic dp;
    logic sup_ack;
    logic commit;
    logic init_req;
  } kcm_state_t;
endpackage : kcm_pkg
